// *** core/vic_top.sv ***
// Vectored priority interrupt controller with a Wishbone register slave.
// Assumes asynchronous source pins and a processor that reads the vectors.
`timescale 1ns/1ps
`include "vic_defs.svh"
module vic_top
    import vic_pkg::*;
#(
    parameter int NSRC = 32,
    parameter int STK_D = 8
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt sources and processor lines
    input wire logic [NSRC-1:0] src_i,
    output logic fast_request_line_n_o,
    output logic normal_request_line_n_o
);
    localparam logic [31:0] VALID = `VIC_SRC_VALID;
    localparam logic [31:0] EXTS = `VIC_SRC_EXT;

    logic ack_reg;
    logic [31:0] dat_reg;
    logic fiq_n_reg;
    logic irq_n_reg;
    logic req;
    logic wr;
    logic rd;
    logic [9:0] badr;
    logic [31:0] wmask;
    logic [31:0] wdat;
    logic [NSRC-1:0] s1_reg;
    logic [NSRC-1:0] s2_reg;
    logic [NSRC-1:0] s3_reg;
    logic [NSRC-1:0] en_reg;
    logic [NSRC-1:0] pend_reg;
    logic [NSRC-1:0] pend_eff;
    vic_prio_t prio_reg [NSRC];
    vic_sens_t sens_reg [NSRC];
    vic_word_t vec_reg [NSRC];
    vic_word_t spu_reg;
    vic_prio_t stk_lvl_reg [STK_D];
    vic_id_t stk_src_reg [STK_D];
    logic [3:0] sp_reg;
    logic [3:0] sp_top;
    vic_prio_t cur_lvl;
    vic_id_t cur_src;
    logic win_valid;
    vic_id_t win_id;
    vic_prio_t win_prio;
    logic above;
    logic ivr_rd;
    logic ivr_take;
    logic fvr_rd;
    logic eoi_wr;
    logic [31:0] rd_mux;
    logic [NSRC-1:0] edge_vec;
    logic edge_hit_any;

    // Bus decode; a request is new while ack has not yet been given
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr = req & wb_we_i;
    assign rd = req & ~wb_we_i;
    assign badr = {wb_adr_i[9:2], 2'b00};
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdat = wb_dat_i & wmask & VALID;
    assign ivr_rd = rd && (badr == `VIC_OFS_IVR);
    assign ivr_take = ivr_rd && above;
    assign fvr_rd = rd && (badr == `VIC_OFS_FVR);
    assign eoi_wr = wr && (badr == `VIC_OFS_EOI);

    // Current interrupt is the top of the level stack
    assign sp_top = sp_reg - 4'h1;
    assign cur_lvl = (sp_reg != 4'h0) ? stk_lvl_reg[sp_top[2:0]] : 3'h0;
    assign cur_src = (sp_reg != 4'h0) ? stk_src_reg[sp_top[2:0]] : 5'h00;

    // Per-source synchroniser, sensitivity, enable, pending and mode
    for (genvar i = 0; i < NSRC; i++)
    begin : g_src
        logic act_now;
        logic act_prev;
        logic is_edge;
        logic edge_hit;
        logic auto_clr;
        logic mode_wr;
        logic vec_wr;
        // Internal sources have fixed active-high polarity
        assign act_now = (EXTS[i] && !sens_reg[i][1]) ? ~s2_reg[i]
                                                      : s2_reg[i];
        assign act_prev = (EXTS[i] && !sens_reg[i][1]) ? ~s3_reg[i]
                                                       : s3_reg[i];
        assign is_edge = sens_reg[i][0];
        assign edge_hit = is_edge & act_now & ~act_prev;
        assign edge_vec[i] = edge_hit;
        assign auto_clr = is_edge && ((ivr_take && win_id == 5'(i)) ||
                                      (fvr_rd && i == 0));
        assign pend_eff[i] = VALID[i] &
                             (pend_reg[i] | (~is_edge & act_now));
        assign mode_wr = wr && wb_sel_i[0] && (badr == 10'(4 * i));
        assign vec_wr = wr && (badr == 10'(`VIC_OFS_VEC + 4 * i));

        // Two flops before any logic, a third for edge history
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                s1_reg[i] <= 1'b0;
                s2_reg[i] <= 1'b0;
                s3_reg[i] <= 1'b0;
            end
            else
            begin
                s1_reg[i] <= src_i[i];
                s2_reg[i] <= s1_reg[i];
                s3_reg[i] <= s2_reg[i];
            end
        end

        // Enable wins over disable when both name the same bit
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                en_reg[i] <= 1'b0;
            else if (wr && badr == `VIC_OFS_IECR && wdat[i])
                en_reg[i] <= 1'b1;
            else if (wr && badr == `VIC_OFS_IDCR && wdat[i])
                en_reg[i] <= 1'b0;
        end

        // A new event wins over a clear in the same cycle
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                pend_reg[i] <= 1'b0;
            else if (VALID[i] && (edge_hit ||
                     (wr && badr == `VIC_OFS_ISCR && wdat[i])))
                pend_reg[i] <= 1'b1;
            else if (auto_clr || (wr && badr == `VIC_OFS_ICCR && wdat[i]))
                pend_reg[i] <= 1'b0;
        end

        // Mode and vector registers, byte lanes honoured
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                prio_reg[i] <= 3'h0;
                sens_reg[i] <= 2'h0;
                vec_reg[i] <= `VIC_RST_WORD;
            end
            else
            begin
                if (mode_wr)
                begin
                    prio_reg[i] <= wb_dat_i[`VIC_PRIO_LSB +: 3];
                    sens_reg[i] <= wb_dat_i[`VIC_SENS_LSB +: 2];
                end
                if (vec_wr)
                    vec_reg[i] <= (vec_reg[i] & ~wmask) | (wb_dat_i & wmask);
            end
        end
    end

    // Top pending source; scanning upward with strict compare keeps ties
    // on the lowest number, and source 0 never enters the normal line
    always_comb
    begin
        win_valid = 1'b0;
        win_id = 5'h00;
        win_prio = 3'h0;
        for (int k = 1; k < NSRC; k++)
        begin
            if (pend_eff[k] && en_reg[k] &&
                (!win_valid || prio_reg[k] > win_prio))
            begin
                win_valid = 1'b1;
                win_id = 5'(k);
                win_prio = prio_reg[k];
            end
        end
        above = win_valid &&
                (sp_reg == 4'h0 || win_prio > cur_lvl);
    end

    // Level stack: push on vector read, pop on end-of-service
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sp_reg <= 4'h0;
        else if (ivr_take && sp_reg < 4'(STK_D))
        begin
            stk_lvl_reg[sp_reg[2:0]] <= win_prio;
            stk_src_reg[sp_reg[2:0]] <= win_id;
            sp_reg <= sp_reg + 4'h1;
        end
        else if (eoi_wr && sp_reg != 4'h0)
            sp_reg <= sp_reg - 4'h1;
    end

    // Spurious vector register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            spu_reg <= `VIC_RST_WORD;
        else if (wr && badr == `VIC_OFS_SPU)
            spu_reg <= (spu_reg & ~wmask) | (wb_dat_i & wmask);
    end

    // Request lines, active low; the line drops the cycle after a vector
    // read and returns only if a higher source is still waiting
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fiq_n_reg <= 1'b1;
            irq_n_reg <= 1'b1;
        end
        else
        begin
            fiq_n_reg <= ~(pend_eff[0] & en_reg[0]);
            irq_n_reg <= ~(above & ~ivr_rd);
        end
    end

    // Read multiplexer; unmapped and write-only words read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (badr[9:7] == 3'h0)
        begin
            rd_mux[`VIC_PRIO_LSB +: 3] = prio_reg[badr[6:2]];
            rd_mux[`VIC_SENS_LSB +: 2] = sens_reg[badr[6:2]];
        end
        else if (badr[9:7] == 3'h1)
            rd_mux = vec_reg[badr[6:2]];
        else
        begin
            case (badr)
                `VIC_OFS_IVR:
                begin
                    if (above)
                        rd_mux = vec_reg[win_id];
                    else if (sp_reg != 4'h0)
                        rd_mux = spu_reg;
                    else
                        rd_mux = 32'h0000_0000;
                end
                `VIC_OFS_FVR: rd_mux = vec_reg[0];
                `VIC_OFS_ISR: rd_mux = {27'h000_0000, cur_src};
                `VIC_OFS_IPR: rd_mux = pend_eff;
                `VIC_OFS_IMR: rd_mux = en_reg;
                `VIC_OFS_CISR: rd_mux = {30'h0000_0000, ~irq_n_reg,
                                         ~fiq_n_reg};
                `VIC_OFS_SPU: rd_mux = spu_reg;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Single-wait-state acknowledge for every address, mapped or not
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= req;
            if (rd)
                dat_reg <= rd_mux;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign fast_request_line_n_o = fiq_n_reg;
    assign normal_request_line_n_o = irq_n_reg;

    // Checks on the design's own outputs and state
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_vec_take;
        ivr_take && sp_reg < 4'(STK_D);
    endsequence

    sequence s_pop;
        eoi_wr && sp_reg != 4'h0;
    endsequence

    a_ack_pulse: assert property (ack_reg |=> !ack_reg)
        else $error("ack held longer than one cycle");
    a_ack_follows: assert property (req |=> ack_reg)
        else $error("request not acknowledged next cycle");
    a_push_level: assert property (s_vec_take |=> (sp_reg ==
        $past(sp_reg) + 4'h1) && cur_lvl == $past(win_prio))
        else $error("vector read did not push level");
    a_pop_level: assert property (s_pop |=>
        sp_reg == $past(sp_reg) - 4'h1)
        else $error("end-of-service did not pop");
    a_irq_drop: assert property (ivr_rd |=> irq_n_reg)
        else $error("normal line stayed active after read");
    a_irq_cause: assert property (!irq_n_reg |-> $past(above))
        else $error("normal line without qualifying source");
    a_fiq_follow: assert property (pend_eff[0] && en_reg[0]
        |=> !fiq_n_reg)
        else $error("fast line not asserted");
    a_enable_set: assert property (wr && badr == `VIC_OFS_IECR |=>
        (en_reg & $past(wdat)) == $past(wdat))
        else $error("enable command lost");
    a_disable_clr: assert property (wr && badr == `VIC_OFS_IDCR |=>
        (en_reg & $past(wdat)) == 32'h0000_0000)
        else $error("disable command lost");
    a_set_pend: assert property (wr && badr == `VIC_OFS_ISCR |=>
        (pend_reg & $past(wdat)) == $past(wdat))
        else $error("set command lost");
    a_cisr_read: assert property (rd && badr == `VIC_OFS_CISR |=>
        dat_reg == {30'h0000_0000, ~$past(irq_n_reg),
                    ~$past(fiq_n_reg)})
        else $error("core line status wrong");
    a_edge_clear: assert property (s_vec_take ##0 sens_reg[win_id][0]
        ##0 !edge_hit_any |=> !pend_reg[$past(win_id)])
        else $error("edge source not cleared on read");
    a_ivr_idle: assert property (ivr_rd && !above && sp_reg == 4'h0
        |=> dat_reg == 32'h0000_0000)
        else $error("idle vector read not zero");

    // Helper for the edge-clear check: any fresh edge this cycle, since a
    // new edge on the taken source legally sets its pending bit again
    assign edge_hit_any = |edge_vec;

endmodule : vic_top

// *** shared/vic_defs.svh ***
// Constants of the vectored interrupt controller: offsets, fields, resets.
// Assumes a 32-bit Wishbone slave with byte addresses in wb_adr_i[9:0].
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH
`define VIC_OFS_MODE 10'h000
`define VIC_OFS_VEC 10'h080
`define VIC_OFS_IVR 10'h100
`define VIC_OFS_FVR 10'h104
`define VIC_OFS_ISR 10'h108
`define VIC_OFS_IPR 10'h10c
`define VIC_OFS_IMR 10'h110
`define VIC_OFS_CISR 10'h114
`define VIC_OFS_IECR 10'h120
`define VIC_OFS_IDCR 10'h124
`define VIC_OFS_ICCR 10'h128
`define VIC_OFS_ISCR 10'h12c
`define VIC_OFS_EOI 10'h130
`define VIC_OFS_SPU 10'h134
`define VIC_PRIO_LSB 0
`define VIC_SENS_LSB 5
`define VIC_SRC_VALID 32'h0007_01ff
`define VIC_SRC_EXT 32'h0007_0001
`define VIC_RST_WORD 32'h0000_0000
`endif

// *** shared/vic_pkg.sv ***
// Types shared by the vectored interrupt controller.
// Assumes the constants header is included alongside.
package vic_pkg;
    typedef logic [2:0] vic_prio_t;
    typedef logic [1:0] vic_sens_t;
    typedef logic [4:0] vic_id_t;
    typedef logic [31:0] vic_word_t;
endpackage : vic_pkg

// *** verif/vic_cpu_model.sv ***
// Processor-side model of the core's input from the controller's normal line.
// Assumes the request lines come straight from the controller.
`timescale 1ns/1ps
module vic_cpu_model
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Controller line and core mask bit
    input wire logic normal_request_line_n_i,
    input wire logic mask_i,
    output logic take_o,
    output logic [31:0] pc_o
);
    // Core takes an unmasked request and branches to the normal slot
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            take_o <= 1'b0;
            pc_o <= 32'h0000_0000;
        end
        else
        begin
            take_o <= !normal_request_line_n_i && !mask_i;
            if (!normal_request_line_n_i && !mask_i)
                pc_o <= 32'h0000_0018;
        end
    end
endmodule : vic_cpu_model

// *** verif/testbench.sv ***
// Self-checking bench: random register traffic against a queue model.
// Assumes a single 100 MHz clock and the controller's Wishbone map.
`timescale 1ns/1ps
`include "vic_defs.svh"
module testbench
    import vic_pkg::*;
;
    localparam vic_word_t VALID = `VIC_SRC_VALID;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, mask = 1'b0;
    logic [9:0] adr = 10'h000;
    vic_word_t dat_w = 32'h0000_0000;
    vic_word_t src = 32'h0000_0000;
    vic_word_t wb_dat_o, rdat, pc, w;
    logic wb_ack_o, fiq_n, irq_n, take;
    int fails = 0, tests_run = 0, n, k;
    // Reference model state
    bit [31:0] pend, en, edg;
    int prio[32];
    vic_word_t vec[32];
    vic_word_t spu;
    int lvl_q[$], id_q[$];

    // Free-running clock
    always #5 clk_i = ~clk_i;

    vic_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .src_i(src), .fast_request_line_n_o(fiq_n),
        .normal_request_line_n_o(irq_n));
    vic_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i),
        .normal_request_line_n_i(irq_n), .mask_i(mask), .take_o(take),
        .pc_o(pc));

    task automatic chk(input vic_word_t got, input vic_word_t exp,
        input string s);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask : chk

    // Classic cycle: hold the request until ack is sampled high
    task automatic bus(input logic wr, input logic [9:0] a, input vic_word_t d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        dat_w <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (n == 20)
            chk(0, 1, "no ack");
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus

    task automatic rd(input logic [9:0] a, input vic_word_t e, input string s);
        bus(1'b0, a, 32'h0000_0000);
        chk(rdat, e, s);
    endtask : rd

    // Highest eligible normal source; ties keep the lowest number
    function automatic int best();
        int b;
        b = -1;
        for (int i = 1; i < 32; i++)
            if (pend[i] && en[i] && (lvl_q.size() == 0 || prio[i] > lvl_q[$]))
                if (b < 0 || prio[i] > prio[b])
                    b = i;
        return b;
    endfunction : best

    // Vector read: push, auto-clear edge source, line drops
    task automatic ivr_read();
        int b;
        vic_word_t e;
        b = best();
        bus(1'b0, `VIC_OFS_IVR, 32'h0000_0000);
        e = (id_q.size() != 0) ? spu : 32'h0000_0000;
        if (b >= 0)
        begin
            e = vec[b];
            lvl_q.push_back(prio[b]);
            id_q.push_back(b);
            if (edg[b])
                pend[b] = 1'b0;
        end
        chk(rdat, e, "vector");
        #1;
        chk(32'(irq_n), 1, "line after read");
    endtask : ivr_read

    // Handler exit: mask, drop level request, end of service
    task automatic eoi();
        mask <= 1'b1;
        if (id_q.size() != 0 && !edg[id_q[$]])
        begin
            bus(1'b1, `VIC_OFS_ICCR, 32'h1 << id_q[$]);
            pend[id_q[$]] = 1'b0;
        end
        bus(1'b1, `VIC_OFS_EOI, $urandom);
        if (id_q.size() != 0)
        begin
            void'(lvl_q.pop_back());
            void'(id_q.pop_back());
        end
        mask <= 1'b0;
    endtask : eoi

    // Lines and status words against the model once things settle
    task automatic settle();
        repeat (4) @(posedge clk_i);
        chk(32'(irq_n), (best() >= 0) ? 0 : 1, "normal");
        chk(32'(fiq_n), !(pend[0] && en[0]), "fast");
        if (take)
            chk(pc, 32'h0000_0018, "branch slot");
        rd(`VIC_OFS_CISR, {30'h0000_0000, best() >= 0, pend[0] & en[0]}, "cisr");
        rd(`VIC_OFS_IPR, pend, "pending");
        rd(`VIC_OFS_ISR, (id_q.size() != 0) ? id_q[$] : 0, "current");
    endtask : settle

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run

    // Hang guard: 20,000 cycles, several times the expected run length
    initial
    begin
        #200_000;
        fails++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        complete_run();
    end

    // Main sequence
    initial
    begin
        n = $urandom(7);
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`VIC_OFS_SPU, 32'h0000_0000, "spu reset");
        rd(`VIC_OFS_CISR, 32'h0000_0000, "cisr reset");
        rd(`VIC_OFS_IVR, 32'h0000_0000, "idle vector");
        rd(10'h118, 32'h0000_0000, "unmapped");
        spu = $urandom;
        bus(1'b1, `VIC_OFS_SPU, spu);
        rd(`VIC_OFS_SPU, spu, "spu");
        $display("reset and spurious test done");
        // Modes and vectors; source 16 rising edge for the pin pulses
        for (int i = 0; i < 32; i++)
        begin
            prio[i] = $urandom % 8;
            edg[i] = (i == 16) ? 1'b1 : 1'($urandom);
            vec[i] = $urandom;
            bus(1'b1, 10'(i * 4), {25'h000_0000, 1'b1, edg[i], 2'b00,
                3'(prio[i])});
            bus(1'b1, 10'(128 + i * 4), vec[i]);
        end
        rd(`VIC_OFS_FVR, vec[0], "fast vector");
        w = $urandom;
        bus(1'b1, `VIC_OFS_IECR, w);
        en = w & VALID;
        w = $urandom & $urandom;
        bus(1'b1, `VIC_OFS_IDCR, w);
        en &= ~w;
        rd(`VIC_OFS_IMR, en, "enables");
        // Low-level polarity on an external source: high pin is idle, low
        // pin is pending; the old mode is restored before random traffic
        src[17] <= 1'b1;
        bus(1'b1, 10'h044, {25'h000_0000, 4'h0, 3'(prio[17])});
        repeat (4) @(posedge clk_i);
        rd(`VIC_OFS_IPR, 32'h0000_0000, "low level idle");
        src[17] <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(`VIC_OFS_IPR, 32'h0002_0000, "low level active");
        bus(1'b1, 10'h044, {25'h000_0000, 1'b1, edg[17], 2'b00,
            3'(prio[17])});
        $display("configuration test done");
        repeat (150)
        begin
            k = $urandom % 6;
            if (take && $urandom % 2)
                k = 2;
            w = $urandom & $urandom;
            case (k)
                0: bus(1'b1, `VIC_OFS_ISCR, w);
                1: bus(1'b1, `VIC_OFS_ICCR, w);
                2: ivr_read();
                3: eoi();
                4: bus(1'b1, `VIC_OFS_IECR, w);
                default:
                begin
                    @(posedge clk_i);
                    src[16] <= 1'b1;
                    repeat (3) @(posedge clk_i);
                    src[16] <= 1'b0;
                end
            endcase
            if (k == 0 || k == 5)
                pend |= (k == 0) ? (w & VALID) : 32'h0001_0000;
            if (k == 1)
                pend &= ~w;
            if (k == 4)
                en |= w & VALID;
            settle();
        end
        $display("random traffic test done");
        complete_run();
    end
endmodule : testbench
